// File: cco_defs.svh
// object indices, field positions, reset values and timing counts
`ifndef CCO_DEFS_SVH
`define CCO_DEFS_SVH

`define CCO_IDX_ERR_REG     16'h1001
`define CCO_IDX_ERR_HIST    16'h1003
`define CCO_IDX_SYNC_ID     16'h1005
`define CCO_IDX_CYCLE       16'h1006
`define CCO_IDX_WINDOW      16'h1007
`define CCO_IDX_EMCY_ID     16'h1014
`define CCO_IDX_INHIBIT     16'h1015
`define CCO_IDX_HB_CONS     16'h1016
`define CCO_IDX_HB_PROD     16'h1017
`define CCO_IDX_IDENTITY    16'h1018

`define CCO_SUB_MAIN        8'h00
`define CCO_HIST_DEPTH      8'h08
`define CCO_HB_CONS_N       8'h04
`define CCO_IDENT_N         8'h04

`define CCO_BIT_GENERIC     0
`define CCO_BIT_CURRENT     1
`define CCO_BIT_VOLTAGE     2
`define CCO_BIT_TEMP        3
`define CCO_BIT_COMM        4
`define CCO_BIT_PROFILE     5
`define CCO_BIT_RSVD        6
`define CCO_BIT_MANUF       7

`define CCO_COB_MSB         10
`define CCO_SYNC_GEN_BIT    30
`define CCO_EMCY_OFF_BIT    31
`define CCO_HB_TIME_MSB     15
`define CCO_HB_NODE_LSB     16
`define CCO_HB_NODE_MSB     23

`define CCO_SYNC_ID_MASK    32'h4000_07FF
`define CCO_EMCY_ID_MASK    32'h8000_07FF
`define CCO_HB_CONS_MASK    32'h00FF_FFFF
`define CCO_U16_MASK        32'h0000_FFFF

`define CCO_SYNC_ID_RST     32'h0000_0080
`define CCO_EMCY_ID_BASE    32'h0000_0080
`define CCO_WORD_RST        32'h0000_0000
`define CCO_HALF_RST        16'h0000

`define CCO_CLK_PERIOD_NS   8
`define CCO_US_NS           1000
`define CCO_CYC_PER_US      ((`CCO_US_NS + `CCO_CLK_PERIOD_NS - 1) / `CCO_CLK_PERIOD_NS)
`define CCO_INHIBIT_UNIT_US 100
`define CCO_MS_US           1000
`define CCO_UNITS_PER_MS    (`CCO_MS_US / `CCO_INHIBIT_UNIT_US)

`endif

// File: cco_pkg.sv
// types shared by the communication-object block
package cco_pkg;

	typedef enum logic [2:0] {
		OD_OK,
		OD_NO_OBJECT,
		OD_NO_SUB,
		OD_READ_ONLY,
		OD_BAD_VALUE
	} cco_status_e;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] index;
		logic [7:0]  sub;
		logic [31:0] wdata;
	} cco_od_req_s;

	typedef struct packed {
		logic        valid;
		cco_status_e status;
		logic [31:0] rdata;
	} cco_od_rsp_s;

	typedef struct packed {
		logic        valid;
		logic [10:0] cob;
		logic [15:0] code;
		logic [15:0] info;
		logic [7:0]  err_reg;
	} cco_emcy_msg_s;

	typedef struct packed {
		logic        valid;
		logic [10:0] cob;
	} cco_sync_msg_s;

endpackage

// File: cco_timebase.sv
// microsecond, 100 microsecond and millisecond tick generator
`timescale 1ns/100ps
`include "cco_defs.svh"
module cco_timebase (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	output logic      tick_us_o,
	output logic      tick_100us_o,
	output logic      tick_ms_o
);
	localparam logic [6:0] CYC_LAST  = 7'(`CCO_CYC_PER_US - 1);
	localparam logic [6:0] US_LAST   = 7'(`CCO_INHIBIT_UNIT_US - 1);
	localparam logic [3:0] UNIT_LAST = 4'(`CCO_UNITS_PER_MS - 1);

	logic [6:0] cyc_reg;
	logic [6:0] us_reg;
	logic [3:0] unit_reg;

	wire cyc_wrap  = cyc_reg == CYC_LAST;
	wire us_wrap   = cyc_wrap && us_reg == US_LAST;
	wire unit_wrap = us_wrap && unit_reg == UNIT_LAST;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cyc_reg      <= '0;
			us_reg       <= '0;
			unit_reg     <= '0;
			tick_us_o    <= 1'b0;
			tick_100us_o <= 1'b0;
			tick_ms_o    <= 1'b0;
		end else begin
			cyc_reg      <= cyc_wrap ? '0 : cyc_reg + 7'd1;
			if (cyc_wrap)
				us_reg <= (us_reg == US_LAST) ? '0 : us_reg + 7'd1;
			if (us_wrap)
				unit_reg <= (unit_reg == UNIT_LAST) ? '0 : unit_reg + 4'd1;
			tick_us_o    <= cyc_wrap;
			tick_100us_o <= us_wrap;
			tick_ms_o    <= unit_wrap;
		end
	end
endmodule

// File: cco_err_history.sv
// error history store, newest entry first, eight deep
`timescale 1ns/100ps
`include "cco_defs.svh"
module cco_err_history (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        clear_i,
	input  wire logic        push_i,
	input  wire logic [31:0] entry_i,
	input  wire logic [7:0]  rd_sub_i,
	output logic      [7:0]  count_o,
	output logic      [31:0] rd_data_o
);
	logic [31:0] hist_mem [0:7];
	logic [3:0]  count_reg;

	wire [7:0] count_w = {4'h0, count_reg};
	wire       rd_hit  = rd_sub_i != 8'h00 && rd_sub_i <= count_w;
	wire [2:0] rd_slot = 3'(rd_sub_i - 8'h01);

	assign count_o   = count_w;
	// slots past the count read zero
	assign rd_data_o = rd_hit ? hist_mem[rd_slot] : '0;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_reg <= '0;
			for (int i = 0; i < 8; i++)
				hist_mem[i] <= '0;
		end else if (push_i) begin
			hist_mem[0] <= entry_i; // see RL20
			for (int i = 1; i < 8; i++)
				hist_mem[i] <= hist_mem[i-1]; // see RL20
			// erase with push keeps only the new entry
			if (clear_i)
				count_reg <= 4'd1;
			else if (count_w != `CCO_HIST_DEPTH)
				count_reg <= count_reg + 4'd1;
		end else if (clear_i) begin
			count_reg <= '0; // see RL6
		end
	end
endmodule

// File: cco_comm_objects.sv
// communication objects: error register, history, sync, emcy, heartbeat
// =====================================================================
// Notes on behaviour
// RL1 - bit0 generic error, bit1 current error
// RL2 - bits 2,3,4: voltage, temperature, communication
// RL3 - bit5 flags device profile errors
// RL4 - bit7 flags manufacturer specific errors
// RL5 - bit6 reserved, always reads zero
// RL6 - history subindex 0 counts; writing zero erases
// RL7 - history entry: code low half, info high
// RL8 - sync identifier in bits 0 to 10
// RL9 - sync identifier bits 11-29, 31 stay zero
// RL10 - bit 30 set enables sync generation
// RL11 - cycle period spaces sync; zero disables all
// RL12 - nonzero window bounds pdo time after sync
// RL13 - emergency identifier bits 0-10, bits 11-30 zero
// RL14 - bit 31 set suppresses emergency messages
// RL15 - emergencies spaced by inhibit, 100us units
// RL16 - consumer entry: timeout, node id, zero top
// RL17 - heartbeat sent every producer time; zero off
// RL18 - identity has four words; vendor reads zero
// RL19 - missing monitored heartbeat flags communication error
// RL20 - newest error first, older shift, eight kept
`timescale 1ns/100ps
`include "cco_defs.svh"
module cco_comm_objects
	import cco_pkg::*;
#(
	parameter logic [6:0]  NODE_ID      = 7'h01,
	parameter logic [31:0] PRODUCT_CODE = 32'h0000_0001, // arbitrary value
	parameter logic [31:0] REVISION     = 32'h0001_0000, // arbitrary value
	parameter logic [31:0] SERIAL       = 32'h0000_0000  // arbitrary value
) (
	input  wire logic          clk_i,
	input  wire logic          rst_n_i,
	input  wire cco_od_req_s   od_req_i,
	output cco_od_rsp_s        od_rsp_o,
	input  wire logic          err_generic_i,
	input  wire logic          err_current_i,
	input  wire logic          err_voltage_i,
	input  wire logic          err_temp_i,
	input  wire logic          err_comm_i,
	input  wire logic          err_profile_i,
	input  wire logic          err_manuf_i,
	input  wire logic          emcy_event_i,
	input  wire logic [15:0]   emcy_code_i,
	input  wire logic [15:0]   emcy_info_i,
	input  wire logic          sync_rx_i,
	input  wire logic          hb_rx_i,
	input  wire logic [7:0]    hb_rx_node_i,
	output cco_emcy_msg_s      emcy_msg_o,
	output cco_sync_msg_s      sync_msg_o,
	output logic               sync_window_o,
	output logic               sync_lost_o,
	output logic               hb_tx_o,
	output logic [3:0]         hb_lost_o,
	output logic [7:0]         err_reg_o
);
	// =================================================================
	// helpers
	function automatic logic fits(input logic [31:0] v,
	                              input logic [31:0] mask);
		fits = (v & ~mask) == '0;
	endfunction

	// =================================================================
	// reset release
	logic rst_meta_reg;
	logic rst_n;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	// =================================================================
	// object storage
	logic [31:0] sync_id_reg;
	logic [31:0] cycle_reg;
	logic [31:0] window_reg;
	logic [31:0] emcy_id_reg;
	logic [15:0] inhibit_reg;
	logic [15:0] hb_prod_reg;
	logic [31:0] hb_cons_reg [0:3];

	logic        tick_us;
	logic        tick_100us;
	logic        tick_ms;
	logic [7:0]  hist_count;
	logic [31:0] hist_data;
	logic [7:0]  err_reg_next;

	cco_timebase u_timebase (
		.clk_i        (clk_i),
		.rst_n_i      (rst_n),
		.tick_us_o    (tick_us),
		.tick_100us_o (tick_100us),
		.tick_ms_o    (tick_ms)
	);

	// =================================================================
	// dictionary access decode
	wire       req_wr = od_req_i.valid & od_req_i.write;
	wire [7:0] sub    = od_req_i.sub;
	wire       sub0   = sub == `CCO_SUB_MAIN;
	wire       sub_hb = !sub0 && sub <= `CCO_HB_CONS_N;
	wire [1:0] hb_sel = 2'(sub - 8'h01);
	wire [31:0] wd    = od_req_i.wdata;

	cco_status_e st_next;
	logic [31:0] rd_next;
	logic        we_sync;
	logic        we_cycle;
	logic        we_window;
	logic        we_emcy;
	logic        we_inhibit;
	logic        we_prod;
	logic        we_cons;
	logic        hist_clr;

	always_comb begin
		st_next    = OD_OK;
		rd_next    = '0;
		we_sync    = 1'b0;
		we_cycle   = 1'b0;
		we_window  = 1'b0;
		we_emcy    = 1'b0;
		we_inhibit = 1'b0;
		we_prod    = 1'b0;
		we_cons    = 1'b0;
		hist_clr   = 1'b0;
		case (od_req_i.index)
			`CCO_IDX_ERR_REG: begin
				if (!sub0)
					st_next = OD_NO_SUB;
				else if (od_req_i.write)
					st_next = OD_READ_ONLY;
				else
					rd_next = {24'h00_0000, err_reg_o};
			end
			`CCO_IDX_ERR_HIST: begin
				if (sub > `CCO_HIST_DEPTH)
					st_next = OD_NO_SUB;
				else if (od_req_i.write && !sub0)
					st_next = OD_READ_ONLY;
				else if (od_req_i.write && wd != 32'h0000_0000)
					st_next = OD_BAD_VALUE;
				else if (od_req_i.write)
					hist_clr = req_wr; // see RL6
				else
					rd_next = sub0 ? {24'h00_0000, hist_count}
					               : hist_data; // see RL6
			end
			`CCO_IDX_SYNC_ID: begin
				if (!sub0)
					st_next = OD_NO_SUB;
				else if (od_req_i.write && !fits(wd, `CCO_SYNC_ID_MASK))
					st_next = OD_BAD_VALUE; // see RL9
				else if (od_req_i.write)
					we_sync = req_wr;
				else
					rd_next = sync_id_reg;
			end
			`CCO_IDX_CYCLE: begin
				if (!sub0)
					st_next = OD_NO_SUB;
				else if (od_req_i.write)
					we_cycle = req_wr;
				else
					rd_next = cycle_reg;
			end
			`CCO_IDX_WINDOW: begin
				if (!sub0)
					st_next = OD_NO_SUB;
				else if (od_req_i.write)
					we_window = req_wr;
				else
					rd_next = window_reg;
			end
			`CCO_IDX_EMCY_ID: begin
				if (!sub0)
					st_next = OD_NO_SUB;
				else if (od_req_i.write && !fits(wd, `CCO_EMCY_ID_MASK))
					st_next = OD_BAD_VALUE; // see RL13
				else if (od_req_i.write)
					we_emcy = req_wr;
				else
					rd_next = emcy_id_reg;
			end
			`CCO_IDX_INHIBIT: begin
				if (!sub0)
					st_next = OD_NO_SUB;
				else if (od_req_i.write && !fits(wd, `CCO_U16_MASK))
					st_next = OD_BAD_VALUE;
				else if (od_req_i.write)
					we_inhibit = req_wr;
				else
					rd_next = {16'h0000, inhibit_reg};
			end
			`CCO_IDX_HB_CONS: begin
				if (!sub0 && !sub_hb)
					st_next = OD_NO_SUB;
				else if (od_req_i.write && sub0)
					st_next = OD_READ_ONLY;
				else if (od_req_i.write && !fits(wd, `CCO_HB_CONS_MASK))
					st_next = OD_BAD_VALUE; // see RL16
				else if (od_req_i.write)
					we_cons = req_wr;
				else
					rd_next = sub0 ? {24'h00_0000, `CCO_HB_CONS_N}
					               : hb_cons_reg[hb_sel];
			end
			`CCO_IDX_HB_PROD: begin
				if (!sub0)
					st_next = OD_NO_SUB;
				else if (od_req_i.write && !fits(wd, `CCO_U16_MASK))
					st_next = OD_BAD_VALUE;
				else if (od_req_i.write)
					we_prod = req_wr;
				else
					rd_next = {16'h0000, hb_prod_reg};
			end
			`CCO_IDX_IDENTITY: begin
				if (sub > `CCO_IDENT_N)
					st_next = OD_NO_SUB;
				else if (od_req_i.write)
					st_next = OD_READ_ONLY;
				else begin
					case (sub) // see RL18
						8'h00:   rd_next = {24'h00_0000, `CCO_IDENT_N};
						8'h02:   rd_next = PRODUCT_CODE;
						8'h03:   rd_next = REVISION;
						8'h04:   rd_next = SERIAL;
						default: rd_next = '0;
					endcase
				end
			end
			default: st_next = OD_NO_OBJECT;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			od_rsp_o    <= '{valid: 1'b0, status: OD_OK, rdata: '0};
			sync_id_reg <= `CCO_SYNC_ID_RST;
			cycle_reg   <= `CCO_WORD_RST;
			window_reg  <= `CCO_WORD_RST;
			emcy_id_reg <= `CCO_EMCY_ID_BASE + {25'h000_0000, NODE_ID};
			inhibit_reg <= `CCO_HALF_RST;
			hb_prod_reg <= `CCO_HALF_RST;
			for (int i = 0; i < 4; i++)
				hb_cons_reg[i] <= `CCO_WORD_RST;
		end else begin
			od_rsp_o.valid  <= od_req_i.valid;
			od_rsp_o.status <= st_next;
			od_rsp_o.rdata  <= rd_next;
			if (we_sync)
				sync_id_reg <= wd;
			if (we_cycle)
				cycle_reg <= wd;
			if (we_window)
				window_reg <= wd;
			if (we_emcy)
				emcy_id_reg <= wd;
			if (we_inhibit)
				inhibit_reg <= wd[15:0];
			if (we_prod)
				hb_prod_reg <= wd[15:0];
			if (we_cons)
				hb_cons_reg[hb_sel] <= wd;
		end
	end

	// =================================================================
	// error history and error register
	cco_err_history u_history (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n),
		.clear_i   (hist_clr),
		.push_i    (emcy_event_i),
		.entry_i   ({emcy_info_i, emcy_code_i}), // see RL7
		.rd_sub_i  (sub),
		.count_o   (hist_count),
		.rd_data_o (hist_data)
	);

	wire comm_err = err_comm_i | sync_lost_o | (|hb_lost_o); // see RL19

	always_comb begin
		err_reg_next                   = 8'h00;
		err_reg_next[`CCO_BIT_CURRENT] = err_current_i; // see RL1
		err_reg_next[`CCO_BIT_VOLTAGE] = err_voltage_i; // see RL2
		err_reg_next[`CCO_BIT_TEMP]    = err_temp_i; // see RL2
		err_reg_next[`CCO_BIT_COMM]    = comm_err; // see RL2
		err_reg_next[`CCO_BIT_PROFILE] = err_profile_i; // see RL3
		err_reg_next[`CCO_BIT_MANUF]   = err_manuf_i; // see RL4
		err_reg_next[`CCO_BIT_RSVD]    = 1'b0; // see RL5
		// any error also raises the generic bit
		err_reg_next[`CCO_BIT_GENERIC] = err_generic_i | (|err_reg_next); // see RL1
	end

	// =================================================================
	// sync generation, checking and window
	wire        sync_on   = cycle_reg != '0; // see RL11
	wire        sync_gen  = sync_on & sync_id_reg[`CCO_SYNC_GEN_BIT]; // see RL10
	wire        sync_chk  = sync_on & ~sync_gen;
	logic [31:0] sync_cnt_reg;
	logic [31:0] win_cnt_reg;
	wire        sync_fire = sync_gen && tick_us
	                        && sync_cnt_reg == cycle_reg - 32'h0000_0001;
	wire        sync_evt  = sync_fire | (sync_chk & sync_rx_i);
	wire        sync_miss = sync_chk && tick_us && sync_cnt_reg == cycle_reg;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sync_cnt_reg  <= '0;
			win_cnt_reg   <= '0;
			sync_msg_o    <= '{valid: 1'b0, cob: 11'h000};
			sync_window_o <= 1'b0;
			sync_lost_o   <= 1'b0;
		end else begin
			if (!sync_on || sync_fire || (sync_chk && sync_rx_i))
				sync_cnt_reg <= '0; // see RL11
			else if (tick_us && sync_cnt_reg != cycle_reg)
				sync_cnt_reg <= sync_cnt_reg + 32'h0000_0001;
			sync_msg_o.valid <= sync_fire; // see RL10
			sync_msg_o.cob   <= sync_id_reg[`CCO_COB_MSB:0]; // see RL8
			// a miss beats a late sync
			if (!sync_chk)
				sync_lost_o <= 1'b0;
			else if (sync_miss)
				sync_lost_o <= 1'b1;
			else if (sync_rx_i)
				sync_lost_o <= 1'b0;
			if (sync_evt && window_reg != '0) begin
				win_cnt_reg   <= window_reg; // see RL12
				sync_window_o <= 1'b1;
			end else if (sync_window_o && tick_us) begin
				win_cnt_reg   <= win_cnt_reg - 32'h0000_0001;
				sync_window_o <= win_cnt_reg != 32'h0000_0001; // see RL12
			end
		end
	end

	// =================================================================
	// emergency transmission with inhibit
	wire         emcy_en   = ~emcy_id_reg[`CCO_EMCY_OFF_BIT]; // see RL14
	logic        emcy_pend_reg;
	logic [15:0] emcy_code_reg;
	logic [15:0] emcy_info_reg;
	logic [16:0] inh_cnt_reg;
	wire         emcy_send = emcy_pend_reg && emcy_en
	                         && inh_cnt_reg == '0;
	// +1 unit covers a partial first tick
	wire [16:0]  inh_load  = (inhibit_reg == 16'h0000) ? 17'h0_0000
	                         : {1'b0, inhibit_reg} + 17'h0_0001;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			emcy_pend_reg <= 1'b0;
			emcy_code_reg <= '0;
			emcy_info_reg <= '0;
			inh_cnt_reg   <= '0;
			emcy_msg_o    <= '0;
			err_reg_o     <= 8'h00;
		end else begin
			err_reg_o <= err_reg_next;
			if (emcy_event_i && emcy_en) begin
				emcy_pend_reg <= 1'b1;
				emcy_code_reg <= emcy_code_i;
				emcy_info_reg <= emcy_info_i;
			end else if (emcy_send || !emcy_en) begin
				emcy_pend_reg <= 1'b0; // see RL14
			end
			if (emcy_send)
				inh_cnt_reg <= inh_load; // see RL15
			else if (tick_100us && inh_cnt_reg != 17'h0_0000)
				inh_cnt_reg <= inh_cnt_reg - 17'h0_0001; // see RL15
			emcy_msg_o.valid   <= emcy_send;
			emcy_msg_o.cob     <= emcy_id_reg[`CCO_COB_MSB:0]; // see RL13
			emcy_msg_o.code    <= emcy_code_reg;
			emcy_msg_o.info    <= emcy_info_reg;
			emcy_msg_o.err_reg <= err_reg_next;
		end
	end

	// =================================================================
	// heartbeat producer and consumers
	logic [15:0] hb_prod_cnt_reg;
	wire         hb_fire = hb_prod_reg != '0 && tick_ms
	                       && hb_prod_cnt_reg == hb_prod_reg - 16'h0001;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			hb_prod_cnt_reg <= 16'h0000;
			hb_tx_o         <= 1'b0;
		end else begin
			if (hb_prod_reg == 16'h0000 || hb_fire)
				hb_prod_cnt_reg <= 16'h0000; // see RL17
			else if (tick_ms)
				hb_prod_cnt_reg <= hb_prod_cnt_reg + 16'h0001;
			hb_tx_o <= hb_fire; // see RL17
		end
	end

	for (genvar g = 0; g < 4; g++) begin : g_cons
		logic [15:0] cnt_reg;
		wire  [15:0] limit  = hb_cons_reg[g][`CCO_HB_TIME_MSB:0];
		wire         active = limit != 16'h0000; // see RL16
		wire         seen   = hb_rx_i && hb_rx_node_i
		                      == hb_cons_reg[g][`CCO_HB_NODE_MSB:`CCO_HB_NODE_LSB];
		wire         wr_me  = we_cons && hb_sel == 2'(g);
		wire         expire = active && tick_ms && cnt_reg == limit;

		always_ff @(posedge clk_i or negedge rst_n) begin
			if (!rst_n) begin
				cnt_reg      <= 16'h0000;
				hb_lost_o[g] <= 1'b0;
			end else begin
				if (!active || seen || wr_me)
					cnt_reg <= 16'h0000;
				else if (tick_ms && cnt_reg != limit)
					cnt_reg <= cnt_reg + 16'h0001;
				if (expire)
					hb_lost_o[g] <= 1'b1; // see RL19
				else if (!active || seen || wr_me)
					hb_lost_o[g] <= 1'b0;
			end
		end
	end
endmodule

// File: cco_comm_objects_checker.sv
// port assertions and covers for the communication object block
`timescale 1ns/100ps
`include "cco_defs.svh"
module cco_comm_objects_checker
	import cco_pkg::*;
(
	input wire logic          clk_i,
	input wire logic          rst_n_i,
	input wire cco_od_req_s   od_req_i,
	input wire cco_od_rsp_s   od_rsp_o,
	input wire logic          err_generic_i,
	input wire logic          err_current_i,
	input wire logic          err_voltage_i,
	input wire logic          err_temp_i,
	input wire logic          err_profile_i,
	input wire logic          err_manuf_i,
	input wire logic          sync_rx_i,
	input wire cco_emcy_msg_s emcy_msg_o,
	input wire cco_sync_msg_s sync_msg_o,
	input wire logic          sync_window_o,
	input wire logic [7:0]    err_reg_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	wire logic wr_v = od_req_i.valid && od_req_i.write;
	wire logic sync_bad = |(od_req_i.wdata & ~`CCO_SYNC_ID_MASK);

	// ==========================================
	// assertions
	chk_rsp_timing: assert property (
		od_rsp_o.valid == $past(od_req_i.valid))
		else $error("late answer");
	chk_ident_ro: assert property (
		wr_v && od_req_i.index == 16'h1018
		|=> od_rsp_o.status == OD_READ_ONLY)
		else $error("identity written");
	chk_sync_bad: assert property (
		wr_v && od_req_i.index == 16'h1005 && od_req_i.sub == 8'h00
		&& sync_bad |=> od_rsp_o.status == OD_BAD_VALUE)
		else $error("bad sync id taken");
	chk_refused_zero: assert property (
		od_rsp_o.valid && od_rsp_o.status != OD_OK
		|-> od_rsp_o.rdata == 32'h0000_0000)
		else $error("refused with data");
	chk_rsvd_zero: assert property (!err_reg_o[6])
		else $error("bit 6 set");
	chk_err_map: assert property (
		{err_reg_o[7], err_reg_o[5], err_reg_o[3:1]} == $past({err_manuf_i,
		err_profile_i, err_temp_i, err_voltage_i, err_current_i}))
		else $error("error bits wrong");
	chk_generic_or: assert property (
		err_reg_o[0] == ($past(err_generic_i) || |err_reg_o[7:1]))
		else $error("generic bit wrong");
	chk_sync_pulse: assert property (
		sync_msg_o.valid |=> !sync_msg_o.valid [*8])
		else $error("sync too soon");
	chk_emcy_pulse: assert property (
		emcy_msg_o.valid |=> !emcy_msg_o.valid)
		else $error("emcy back to back");
	chk_window_cause: assert property (
		$rose(sync_window_o) |-> sync_msg_o.valid || $past(sync_msg_o.valid)
		|| $past(sync_rx_i) || $past(sync_rx_i, 2))
		else $error("stray window");

	cov_sync: cover property (sync_msg_o.valid);
	cov_emcy: cover property (emcy_msg_o.valid);
	cov_refuse: cover property (od_rsp_o.valid && od_rsp_o.status != OD_OK);
endmodule

bind cco_comm_objects cco_comm_objects_checker u_chk (.*);

// File: cco_far_node.sv
// far-side node model: sends sync and heartbeat frames
`timescale 1ns/100ps
module cco_far_node #(
	parameter int         SYNC_CYC = 250,
	parameter int         HB_CYC   = 5000,
	parameter logic [7:0] NODE     = 8'h05
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       sync_on_i,
	output logic            sync_rx_o,
	output logic            hb_rx_o,
	output logic      [7:0] hb_node_o
);
	int sync_reg;
	int hb_reg;
	wire logic hb_hit = (hb_reg == HB_CYC - 1);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync_reg <= 0;
			hb_reg <= 0;
			sync_rx_o <= 1'b0;
			hb_rx_o <= 1'b0;
			hb_node_o <= 8'h00;
		end else begin
			sync_reg <= (sync_reg == SYNC_CYC - 1) ? 0 : sync_reg + 1;
			sync_rx_o <= sync_on_i && sync_reg == SYNC_CYC - 1;
			hb_reg <= hb_hit ? 0 : hb_reg + 1;
			hb_rx_o <= hb_hit;
			// idle node lines do not hold
			hb_node_o <= hb_hit ? NODE : ~hb_node_o;
		end
	end
endmodule

// File: tb_canopen_comm_objects.sv
// self-checking bench for the communication object block
`timescale 1ns/100ps
module tb_canopen_comm_objects
	import cco_pkg::*;
;
	logic          clk_i = 1'b0;
	logic          rst_n_i = 1'b0;
	cco_od_req_s   req = '0;
	logic [6:0]    err = '0;
	logic          ev = 1'b0;
	logic [15:0]   code = '0;
	logic          sync_on = 1'b0;
	logic          hb_tx;
	int            n_hb = 0;
	cco_od_rsp_s   rsp;
	cco_emcy_msg_s emcy;
	cco_emcy_msg_s emcy_got;
	cco_sync_msg_s sync;
	cco_sync_msg_s sync_got;
	logic          sync_rx;
	logic          hb_rx;
	logic [7:0]    hb_node;
	logic          lost;
	logic [3:0]    hb_lost;
	logic [7:0]    ereg;
	int            bad_count = 0;
	int            n_compared = 0;
	int            cyc = 0;
	int            n_emcy = 0;
	int            emcy_at = 0;
	int            emcy_gap = 0;
	int            n_sync = 0;
	int            sync_at = 0;
	int            sync_gap = 0;
	int            i;

	always #4 clk_i = ~clk_i;

	cco_comm_objects uut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .od_req_i(req), .od_rsp_o(rsp),
		.err_generic_i(err[0]), .err_current_i(err[1]),
		.err_voltage_i(err[2]), .err_temp_i(err[3]), .err_comm_i(err[4]),
		.err_profile_i(err[5]), .err_manuf_i(err[6]),
		.emcy_event_i(ev), .emcy_code_i(code), .emcy_info_i(~code),
		.sync_rx_i(sync_rx), .hb_rx_i(hb_rx), .hb_rx_node_i(hb_node),
		.emcy_msg_o(emcy), .sync_msg_o(sync), .sync_window_o(),
		.sync_lost_o(lost), .hb_tx_o(hb_tx), .hb_lost_o(hb_lost),
		.err_reg_o(ereg)
	);

	cco_far_node far (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .sync_on_i(sync_on),
		.sync_rx_o(sync_rx), .hb_rx_o(hb_rx), .hb_node_o(hb_node)
	);

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (hb_tx === 1'b1)
			n_hb <= n_hb + 1;
		if (emcy.valid === 1'b1) begin
			n_emcy <= n_emcy + 1;
			emcy_gap <= cyc - emcy_at;
			emcy_at <= cyc;
			emcy_got <= emcy;
		end
		if (sync.valid === 1'b1) begin
			n_sync <= n_sync + 1;
			sync_gap <= cyc - sync_at;
			sync_at <= cyc;
			sync_got <= sync;
		end
	end

	// ==========================================
	// tasks
	task automatic check(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic acc(input logic w, input logic [15:0] ix,
		input logic [7:0] sb, input logic [31:0] wd,
		input cco_status_e st, input logic [31:0] exp);
		@(posedge clk_i);
		req <= '{1'b1, w, ix, sb, wd};
		@(posedge clk_i);
		req.valid <= 1'b0;
		#1;
		check("answer", rsp.valid, 32'h0000_0001);
		check("status", rsp.status, st);
		check("rdata", rsp.rdata, exp);
	endtask

	task automatic rd(input logic [15:0] ix, input logic [7:0] sb,
		input logic [31:0] exp);
		acc(1'b0, ix, sb, '0, OD_OK, exp);
	endtask

	task automatic wr(input logic [15:0] ix, input logic [7:0] sb,
		input logic [31:0] wd, input cco_status_e st);
		acc(1'b1, ix, sb, wd, st, '0);
	endtask

	task automatic fire(input logic [15:0] c);
		@(posedge clk_i);
		ev <= 1'b1;
		code <= c;
		@(posedge clk_i);
		ev <= 1'b0;
	endtask

	// an expired wait fails the run
	task automatic wait_cnt(ref int n, input int tgt, input int lim);
		for (int k = 0; k < lim && n < tgt; k++)
			@(posedge clk_i);
		if (n < tgt) begin
			bad_count++;
			give_verdict();
		end
	endtask

	// ==========================================
	// main sequence
	initial begin
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rd(16'h1005, 8'h00, 32'h0000_0080);
		rd(16'h1014, 8'h00, 32'h0000_0081);
		rd(16'h1018, 8'h00, 32'h0000_0004);
		rd(16'h1018, 8'h01, 32'h0000_0000);
		rd(16'h1016, 8'h00, 32'h0000_0004);
		rd(16'h1003, 8'h00, 32'h0000_0000);
		wr(16'h1018, 8'h02, 32'h0000_0000, OD_READ_ONLY);
		wr(16'h1005, 8'h00, 32'h8000_0080, OD_BAD_VALUE);
		wr(16'h1005, 8'h00, 32'h0000_0880, OD_BAD_VALUE);
		wr(16'h1014, 8'h00, 32'h4000_0081, OD_BAD_VALUE);
		wr(16'h1016, 8'h01, 32'h0100_0001, OD_BAD_VALUE);
		wr(16'h1015, 8'h00, 32'h0001_0000, OD_BAD_VALUE);
		wr(16'h1017, 8'h00, 32'h0001_0000, OD_BAD_VALUE);
		wr(16'h1000, 8'h00, 32'h0000_0000, OD_NO_OBJECT);
		acc(1'b0, 16'h1003, 8'h09, 32'h0000_0000, OD_NO_SUB, 32'h0000_0000);
		rd(16'h1005, 8'h00, 32'h0000_0080);
		wr(16'h1016, 8'h01, 32'h0005_0001, OD_OK);
		rd(16'h1016, 8'h01, 32'h0005_0001);
		for (i = 0; i < 7; i++) begin
			err <= 7'(1 << i);
			repeat (3) @(posedge clk_i);
			check("error reg", ereg, 8'(1 << (i + (i == 6))) | 8'h01);
		end
		err <= 7'h7F;
		repeat (3) @(posedge clk_i);
		check("error reg all", ereg, 8'hBF);
		err <= 7'h00;
		fire(16'h1000);
		wait_cnt(n_emcy, 1, 50);
		check("emcy id", emcy_got.cob, 11'h081);
		check("emcy code", {emcy_got.info, emcy_got.code}, 32'hEFFF_1000);
		wr(16'h1015, 8'h00, 32'h0000_0001, OD_OK);
		fire(16'h2000);
		fire(16'h3000);
		wait_cnt(n_emcy, 3, 30000);
		check("inhibit gap", emcy_gap >= 12500 && emcy_gap < 25004, 1);
		wr(16'h1014, 8'h00, 32'h8000_0081, OD_OK);
		for (i = 0; i < 9; i++)
			fire(16'h0100 + 16'(i));
		repeat (300) @(posedge clk_i);
		check("emcy count", n_emcy, 3);
		rd(16'h1003, 8'h00, 32'h0000_0008);
		rd(16'h1003, 8'h01, 32'hFEF7_0108);
		rd(16'h1003, 8'h08, 32'hFEFE_0101);
		wr(16'h1003, 8'h00, 32'h0000_0001, OD_BAD_VALUE);
		wr(16'h1003, 8'h00, 32'h0000_0000, OD_OK);
		rd(16'h1003, 8'h00, 32'h0000_0000);
		rd(16'h1003, 8'h01, 32'h0000_0000);
		wr(16'h1007, 8'h00, 32'h0000_0001, OD_OK);
		wr(16'h1006, 8'h00, 32'h0000_0003, OD_OK);
		wr(16'h1005, 8'h00, 32'h4000_0080, OD_OK);
		wait_cnt(n_sync, 3, 2000);
		check("sync gap", sync_gap, 375);
		check("sync id", sync_got.cob, 11'h080);
		wr(16'h1005, 8'h00, 32'h0000_0080, OD_OK);
		i = n_sync;
		repeat (1000) @(posedge clk_i);
		check("sync stopped", n_sync, i);
		check("sync lost", lost, 1'b1);
		check("comm bit", ereg[4], 1'b1);
		sync_on <= 1'b1;
		repeat (1000) @(posedge clk_i);
		check("sync seen", lost, 1'b0);
		sync_on <= 1'b0;
		wr(16'h1006, 8'h00, 32'h0000_0000, OD_OK);
		repeat (1000) @(posedge clk_i);
		check("no checking", lost, 1'b0);
		check("heartbeat kept", hb_lost, 4'h0);
		check("heartbeat sent", n_hb, 32'h0000_0000);
		give_verdict();
	end
endmodule
